// ---- slp_ctrl_model.sv ----
`timescale 1ns/1ns
module slp_ctrl_model (
  output logic SHIFT_CLOCK,
  output logic LATCH_STROBE,
  output logic SERIAL_IN,
  output logic GRAYSCALE_CLOCK,
  input wire logic SERIAL_OUT
);
  initial
  begin
    SHIFT_CLOCK = 1'b0;
    LATCH_STROBE = 1'b0;
    SERIAL_IN = 1'b0;
    GRAYSCALE_CLOCK = 1'b0;
  end

  // ----------------------------------------------------------------
  // link: one 30 ns shift clock period, clock stands still afterwards
  // ----------------------------------------------------------------
  task automatic edge_out(input logic le, input logic d);
    LATCH_STROBE = le;
    SERIAL_IN = d;
    #13 SHIFT_CLOCK = 1'b1;
    #15 SHIFT_CLOCK = 1'b0;
    #2;
  endtask

  task automatic idle_edges(input int n);
    int i;
    for (i = 0; i < n; i++)
      edge_out(1'b0, ~SERIAL_IN);
  endtask

  // strobe high for the last n edges; data commands shift msb first
  task automatic send(input int n, input logic [15:0] w, input bit dat);
    int i;
    for (i = dat ? 15 : n - 1; i >= 0; i--)
      edge_out(i < n, w[i]);
    edge_out(1'b0, ~SERIAL_IN);
  endtask

  task automatic read_cfg(output logic [15:0] v);
    int i;
    for (i = 0; i < 5; i++)
      edge_out(1'b1, ~SERIAL_IN);
    for (i = 15; i >= 0; i--)
    begin
      edge_out(1'b0, ~SERIAL_IN);
      v[i] = SERIAL_OUT;
    end
  endtask

  // ----------------------------------------------------------------
  // grayscale clock: 150 ns, a fifth of the shift clock rate
  // ----------------------------------------------------------------
  task automatic grayscale_clock_pulse();
    GRAYSCALE_CLOCK = 1'b1;
    #80 GRAYSCALE_CLOCK = 1'b0;
    #70;
  endtask
endmodule

// ---- slp_frame_pwm.sv ----
`timescale 1ns/1ns
// What this block does
// - soft reset clears link and display state but keeps the configuration, bank select and frame store
// - after soft reset outputs stay off until frame sync or an unlocked force-on, then old data
// - force-on lights every channel, only right after unlock
// - force-off darkens every channel, only right after unlock
// - a word latch cancels any force-on or force-off
// - 16-bit read/write configuration register, reset value 16'h032B
// - config bit D picks grayscale clock: pin when 0, shift clock when 1
// - bit C: 64 or 16 sections of 1024 grayscale clocks
// - config bits A..8 give scan lines minus one, default four lines
// - config bits 5..0 select current gain step, default 6'b101011
// - two-bank frame store, banks swap at each frame sync
// - store order: line 0 first, channel 15 down to channel 0
// - next frame is written while current bank displays repeatedly
// - outputs stay idle from power-up until the first frame sync or an unlocked force-on
// - command set by count of shift clock edges while strobe high
// - word latch stores last 16 bits shifted in, msb first
// - unlocked write config loads last 16 bits shifted in, msb first
module slp_frame_pwm (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic SHIFT_CLOCK,
  input wire logic LATCH_STROBE,
  input wire logic SERIAL_IN,
  input wire logic GRAYSCALE_CLOCK,
  output logic SERIAL_OUT,
  output logic [slp_pkg::NUM_CH-1:0] CHANNEL_OUTPUTS,
  output logic [slp_pkg::GAIN_W-1:0] CURRENT_GAIN
);
  import slp_pkg::*;

  function automatic logic is_known(input logic [CMD_W-1:0] c);
    is_known = (c == CMD_WORD_LATCH) || (c == CMD_FRAME_SYNC) ||
               (c == CMD_WRITE_CFG) || (c == CMD_READ_CFG) ||
               (c == CMD_SOFT_RESET) || (c == CMD_FORCE_ON) ||
               (c == CMD_FORCE_OFF) || (c == CMD_UNLOCK);
  endfunction

  // on time in one section: coarse part, plus one spread clock while the section is below the fine part
  function automatic logic [CNT_W-1:0] on_time(
    input logic [WORD_W-1:0] w,
    input logic [SECT_W-1:0] s,
    input logic m14
  );
    logic extra;
    extra = m14 ? (s[3:0] < w[5:2]) : (s < w[5:0]);
    on_time = {1'b0, w[15:6]} + {10'h000, extra};
  endfunction

  // ----------------------------------------------------------------
  // link domain: reset and command capture
  // ----------------------------------------------------------------
  logic link_rst_b;
  logic strobe_d_reg;
  logic [CMD_W-1:0] edge_cnt_reg;
  logic [WORD_W-1:0] shift_reg;
  logic exec;
  logic link_clr;
  logic unlock_reg;
  logic [1:0] force_reg;
  logic [WORD_W-1:0] cfg_reg;
  logic bank_reg;
  logic [PTR_W-1:0] wr_ptr_reg;
  logic frame_tgl_reg;
  logic rst_tgl_reg;
  logic [WORD_W-1:0] rd_shift_reg;
  logic [4:0] rd_cnt_reg;
  logic [WORD_W-1:0] mem [0:MEM_WORDS-1];
  logic is_word, is_sync, is_wcfg, is_rcfg, is_rst, is_fon, is_foff;

  slp_sync #(.WIDTH(1)) u_link_rst (
    .clk(SHIFT_CLOCK),
    .rst_b(1'b1),
    .din(RST_B),
    .dout(link_rst_b)
  );

  // command runs at the first edge seen with the strobe low
  assign exec = strobe_d_reg && !LATCH_STROBE;
  assign is_word = exec && (edge_cnt_reg == CMD_WORD_LATCH);
  assign is_sync = exec && (edge_cnt_reg == CMD_FRAME_SYNC);
  assign is_wcfg = exec && (edge_cnt_reg == CMD_WRITE_CFG);
  assign is_rcfg = exec && (edge_cnt_reg == CMD_READ_CFG);
  assign is_rst = exec && (edge_cnt_reg == CMD_SOFT_RESET);
  assign is_fon = exec && (edge_cnt_reg == CMD_FORCE_ON);
  assign is_foff = exec && (edge_cnt_reg == CMD_FORCE_OFF);
  assign link_clr = !link_rst_b || is_rst;

  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (!link_rst_b)
    begin
      strobe_d_reg <= 1'b0;
      edge_cnt_reg <= '0;
    end
    else
    begin
      strobe_d_reg <= LATCH_STROBE;
      if (!LATCH_STROBE)
        edge_cnt_reg <= '0;
      else if (edge_cnt_reg != CMD_MAX)
        edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  // shifts on every edge, so it holds the bits before the strobe fell
  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (link_clr)
      shift_reg <= '0;
    else
      shift_reg <= {shift_reg[WORD_W-2:0], SERIAL_IN};
  end

  // ----------------------------------------------------------------
  // link domain: unlock, force, configuration
  // ----------------------------------------------------------------
  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (link_clr)
      unlock_reg <= 1'b0;
    else if (exec && is_known(edge_cnt_reg))
      unlock_reg <= (edge_cnt_reg == CMD_UNLOCK);
  end

  // force_reg[0] is force-on, force_reg[1] is force-off
  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (link_clr)
      force_reg <= 2'h0;
    else if (is_word)
      force_reg <= 2'h0;
    else if (is_fon && unlock_reg)
      force_reg <= 2'h1;
    else if (is_foff && unlock_reg)
      force_reg <= 2'h2;
  end

  // soft reset does not touch the configuration
  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (!link_rst_b)
      cfg_reg <= CFG_RESET;
    else if (is_wcfg && unlock_reg)
      cfg_reg <= shift_reg;
  end

  // read back, msb first, on the edges after the command
  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (link_clr)
    begin
      rd_shift_reg <= '0;
      rd_cnt_reg <= '0;
    end
    else if (is_rcfg)
    begin
      rd_shift_reg <= cfg_reg;
      rd_cnt_reg <= RD_BITS;
    end
    else if (rd_cnt_reg != 5'h00)
    begin
      rd_shift_reg <= {rd_shift_reg[WORD_W-2:0], 1'b0};
      rd_cnt_reg <= rd_cnt_reg - 5'h01;
    end
  end

  assign SERIAL_OUT = (rd_cnt_reg != 5'h00) ? rd_shift_reg[WORD_W-1] :
                      shift_reg[WORD_W-1];

  // ----------------------------------------------------------------
  // link domain: frame store writes and bank swap
  // ----------------------------------------------------------------
  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (link_clr || is_sync)
      wr_ptr_reg <= '0;
    else if (is_word)
      wr_ptr_reg <= wr_ptr_reg + 7'h01;
  end

  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (is_word)
      mem[{bank_reg, wr_ptr_reg}] <= shift_reg;
  end

  // bank survives soft reset so the last frame can come back
  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (!link_rst_b)
      bank_reg <= 1'b0;
    else if (is_sync)
      bank_reg <= ~bank_reg;
  end

  always_ff @(posedge SHIFT_CLOCK)
  begin
    if (!link_rst_b)
    begin
      frame_tgl_reg <= 1'b0;
      rst_tgl_reg <= 1'b0;
    end
    else
    begin
      if (is_sync)
        frame_tgl_reg <= ~frame_tgl_reg;
      if (is_rst)
        rst_tgl_reg <= ~rst_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // crossing into the core domain
  // ----------------------------------------------------------------
  logic [22:0] sync_out;
  logic [20:0] held_reg;
  logic [20:0] link_c_reg;
  logic gs_pin_s, sh_pin_s, bank_s, frame_tgl_s, rst_tgl_s;
  logic [WORD_W-1:0] cfg_s;
  logic [1:0] force_s;

  slp_sync #(.WIDTH(23)) u_core_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .din({GRAYSCALE_CLOCK, SHIFT_CLOCK, cfg_reg, force_reg, bank_reg,
          frame_tgl_reg, rst_tgl_reg}),
    .dout(sync_out)
  );

  assign {gs_pin_s, sh_pin_s} = sync_out[22:21];

  // link state is taken only after two equal samples, so a word caught
  // while its bits change together is never used
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      held_reg <= '0;
      link_c_reg <= '0;
    end
    else
    begin
      held_reg <= sync_out[20:0];
      if (held_reg == sync_out[20:0])
        link_c_reg <= sync_out[20:0];
    end
  end

  assign {cfg_s, force_s, bank_s, frame_tgl_s, rst_tgl_s} = link_c_reg;

  // ----------------------------------------------------------------
  // core domain: grayscale clock edges and events
  // ----------------------------------------------------------------
  logic gs_sel, gs_sel_d_reg, gs_edge;
  logic frame_tgl_d_reg, rst_tgl_d_reg, frame_pulse, rst_pulse;
  logic mode14;
  logic [LINE_W-1:0] lines_m1;
  slp_disp_e disp_state;
  logic [CNT_W-1:0] cnt_reg;
  logic [LINE_W-1:0] line_reg;
  logic [SECT_W-1:0] sect_reg;
  logic [SECT_W-1:0] sect_last;
  logic [NUM_CH-1:0] chan_on;

  assign gs_sel = cfg_s[CFG_GS_SRC_BIT] ? sh_pin_s : gs_pin_s;
  assign gs_edge = gs_sel && !gs_sel_d_reg;
  assign frame_pulse = frame_tgl_s ^ frame_tgl_d_reg;
  assign rst_pulse = rst_tgl_s ^ rst_tgl_d_reg;
  assign mode14 = cfg_s[CFG_MODE14_BIT];
  assign lines_m1 = cfg_s[CFG_LINES_LSB +: LINE_W];
  assign sect_last = mode14 ? SECT_LAST_14 : SECT_LAST_16;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      gs_sel_d_reg <= 1'b0;
      frame_tgl_d_reg <= 1'b0;
      rst_tgl_d_reg <= 1'b0;
      CURRENT_GAIN <= '0;
    end
    else
    begin
      gs_sel_d_reg <= gs_sel;
      frame_tgl_d_reg <= frame_tgl_s;
      rst_tgl_d_reg <= rst_tgl_s;
      CURRENT_GAIN <= cfg_s[CFG_GAIN_LSB +: GAIN_W];
    end
  end

  // ----------------------------------------------------------------
  // core domain: display state and pwm counters
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B || rst_pulse)
      disp_state <= SLP_IDLE;
    else if (frame_pulse)
      disp_state <= SLP_ACTIVE;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B || rst_pulse || frame_pulse)
    begin
      cnt_reg <= GS_OFF;
      line_reg <= '0;
      sect_reg <= '0;
    end
    else if (gs_edge && disp_state == SLP_ACTIVE)
    begin
      unique case (cnt_reg)
        GS_OFF:
        begin
          cnt_reg <= '0;
        end
        GS_LAST:
        begin
          cnt_reg <= '0;
          if (line_reg >= lines_m1)
          begin
            line_reg <= '0;
            sect_reg <= (sect_reg >= sect_last) ? 6'h00 :
                        sect_reg + 6'h01;
          end
          else
            line_reg <= line_reg + 3'h1;
        end
        default:
        begin
          cnt_reg <= cnt_reg + 11'h001;
        end
      endcase
    end
  end

  // read bank is the one not being written
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      localparam logic [SLOT_W-1:0] SLOT = SLOT_W'(NUM_CH - 1 - g);
      logic [WORD_W-1:0] word;
      assign word = mem[{~bank_s, line_reg, SLOT}];
      assign chan_on[g] = cnt_reg < on_time(word, sect_reg, mode14);
    end
  endgenerate

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      CHANNEL_OUTPUTS <= '0;
    else if (force_s[0])
      CHANNEL_OUTPUTS <= '1;
    else if (force_s[1])
      CHANNEL_OUTPUTS <= '0;
    else if (disp_state == SLP_ACTIVE)
      CHANNEL_OUTPUTS <= chan_on;
    else
      CHANNEL_OUTPUTS <= '0;
  end

  // ----------------------------------------------------------------
  // checks, link domain
  // ----------------------------------------------------------------
  sequence s_word_latch;
    is_word;
  endsequence

  sequence s_unknown_cmd;
    exec && !is_known(edge_cnt_reg);
  endsequence

  a_reset_keeps_cfg: assert property (
    @(posedge SHIFT_CLOCK) disable iff (!link_rst_b)
    is_rst |=> $stable(cfg_reg) && unlock_reg == 1'b0 && force_reg == 2'h0)
    else $error("soft reset disturbed config or left state set");

  a_cfg_needs_unlock: assert property (
    @(posedge SHIFT_CLOCK) disable iff (!link_rst_b)
    is_wcfg && !unlock_reg |=> $stable(cfg_reg))
    else $error("config written without unlock");

  a_cfg_load: assert property (
    @(posedge SHIFT_CLOCK) disable iff (!link_rst_b)
    is_wcfg && unlock_reg |=> cfg_reg == $past(shift_reg))
    else $error("config not loaded from shift register");

  a_latch_clears_force: assert property (
    @(posedge SHIFT_CLOCK) disable iff (!link_rst_b)
    s_word_latch |=> force_reg == 2'h0)
    else $error("force state survived word latch");

  a_word_ptr_step: assert property (
    @(posedge SHIFT_CLOCK) disable iff (!link_rst_b)
    s_word_latch |=> wr_ptr_reg == $past(wr_ptr_reg) + 7'h01)
    else $error("write pointer did not advance");

  a_bank_swap: assert property (
    @(posedge SHIFT_CLOCK) disable iff (!link_rst_b)
    is_sync |=> bank_reg != $past(bank_reg) && wr_ptr_reg == '0)
    else $error("frame sync did not swap banks");

  a_unknown_ignored: assert property (
    @(posedge SHIFT_CLOCK) disable iff (!link_rst_b)
    s_unknown_cmd |=> $stable(cfg_reg) && $stable(force_reg) &&
                      $stable(unlock_reg) && $stable(bank_reg))
    else $error("unknown command changed state");

  // ----------------------------------------------------------------
  // checks, core domain
  // ----------------------------------------------------------------
  sequence s_last_clock;
    disp_state == SLP_ACTIVE && gs_edge && cnt_reg == GS_LAST &&
    !frame_pulse && !rst_pulse;
  endsequence

  a_force_on_out: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    force_s[0] |=> CHANNEL_OUTPUTS == {NUM_CH{1'b1}})
    else $error("force-on did not light all channels");

  a_idle_dark: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    disp_state == SLP_IDLE && force_s == 2'h0 |=> CHANNEL_OUTPUTS == '0)
    else $error("outputs lit while idle");

  a_sync_preset: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    frame_pulse && !rst_pulse |=> cnt_reg == GS_OFF &&
                                  disp_state == SLP_ACTIVE)
    else $error("frame sync did not preset counter");

  a_period_wrap: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    s_last_clock |=> cnt_reg == '0)
    else $error("section did not end after 1024 clocks");

  a_soft_reset_idle: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    rst_pulse |=> disp_state == SLP_IDLE ##1 CHANNEL_OUTPUTS == '0)
    else $error("soft reset did not darken outputs");

endmodule

// ---- slp_frame_pwm_tb.sv ----
`timescale 1ns/1ns
module slp_frame_pwm_tb;
  import slp_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic SHIFT_CLOCK;
  logic LATCH_STROBE;
  logic SERIAL_IN;
  logic GRAYSCALE_CLOCK;
  logic SERIAL_OUT;
  logic [NUM_CH-1:0] CHANNEL_OUTPUTS;
  logic [GAIN_W-1:0] CURRENT_GAIN;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 68976;
  int frame [2][128];
  int wb = 0;
  int wp = 0;
  int cnt = 1024;
  int ln = 0;
  int sc = 0;
  int force_v = 0;
  bit act = 1'b0;
  bit unl = 1'b0;
  bit chk_en = 1'b1;
  logic [15:0] cfg_m = CFG_RESET;
  logic [15:0] rd;
  logic [15:0] exp_o;
  logic [15:0] cv;

  always #5 CORE_CLK = ~CORE_CLK;

  slp_frame_pwm i_dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
    .SHIFT_CLOCK(SHIFT_CLOCK), .LATCH_STROBE(LATCH_STROBE),
    .SERIAL_IN(SERIAL_IN), .GRAYSCALE_CLOCK(GRAYSCALE_CLOCK),
    .SERIAL_OUT(SERIAL_OUT), .CHANNEL_OUTPUTS(CHANNEL_OUTPUTS),
    .CURRENT_GAIN(CURRENT_GAIN));

  slp_ctrl_model i_ctrl (.SHIFT_CLOCK(SHIFT_CLOCK),
    .LATCH_STROBE(LATCH_STROBE), .SERIAL_IN(SERIAL_IN),
    .GRAYSCALE_CLOCK(GRAYSCALE_CLOCK), .SERIAL_OUT(SERIAL_OUT));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // reference model of the command decoder and the display
  // ----------------------------------------------------------------
  task automatic cmd(input int n, input logic [15:0] w);
    bit ok;
    ok = unl;
    if (force_v != 0 || n >= 10)
      chk_en = 1'b0;
    i_ctrl.send(n, w, n == 1 || n == 4);
    if (n > 0 && n < 6 && n != 2 || n > 9 && n < 15 && n != 13)
      unl = (n == 14);
    case (n)
      1:
      begin
        frame[wb][wp] = w;
        wp = (wp + 1) % 128;
        force_v = 0;
      end
      3:
      begin
        wb ^= 1;
        wp = 0;
        act = 1'b1;
        cnt = 1024;
        ln = 0;
        sc = 0;
      end
      4: if (ok) cfg_m = w;
      10:
      begin
        act = 1'b0;
        wp = 0;
        force_v = 0;
      end
      11: if (ok) force_v = 1;
      12: if (ok) force_v = 2;
      default: ;
    endcase
    #200;
    chk_en = 1'b1;
  endtask

  task automatic grayscale_clock_run(input int n);
    int i;
    int ch;
    int w;
    int nl;
    for (i = 0; i < n; i++)
    begin
      nl = cfg_m[10:8] + 1;
      if (act && cnt == 1023 && ln == nl - 1)
        sc = (sc + 1) % (cfg_m[12] ? 16 : 64);
      if (act && cnt == 1023)
        ln = (ln + 1) % nl;
      if (act)
        cnt = (cnt >= 1023) ? 0 : cnt + 1;
      for (ch = 0; ch < 16; ch++)
      begin
        w = frame[wb ^ 1][ln * 16 + 15 - ch];
        exp_o[ch] = act && cnt < 1024 && cnt < (w >> 6) +
                    ((sc < (cfg_m[12] ? (w >> 2) & 15 : w & 63)) ? 1 : 0);
      end
      if (force_v == 1)
        exp_o = 16'hFFFF;
      if (force_v == 2)
        exp_o = 16'h0000;
      i_ctrl.grayscale_clock_pulse();
      if (chk_en)
        check(CHANNEL_OUTPUTS, exp_o, "channels");
    end
  endtask

  task automatic load(input int n);
    int i;
    for (i = 0; i < n; i++)
      cmd(1, 16'($random(seed)) &
          (cfg_m[12] ? 16'hFFFC : 16'hFFFF));
  endtask

  task automatic read_chk();
    i_ctrl.read_cfg(rd);
    unl = 1'b0;
    check(rd, cfg_m, "config read");
  endtask

  // force or word latch commands are sent while the grayscale clock keeps running
  task automatic during(input int n, input bit u);
    fork
      grayscale_clock_run(40);
      begin
        if (u)
          cmd(14, 16'h0000);
        cmd(n, 16'($random(seed)));
      end
    join
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fork
      i_ctrl.idle_edges(4);
      repeat (12) @(posedge CORE_CLK);
    join
    @(posedge CORE_CLK);
    #1 RST_B = 1'b1;
    i_ctrl.idle_edges(3);
    repeat (10) @(posedge CORE_CLK);
    #1;
    check({10'h000, CURRENT_GAIN}, {10'h000, 6'h2B}, "gain");
    check(CHANNEL_OUTPUTS, 16'h0000, "idle");
    read_chk();
    cv = 16'h0100 | 16'($unsigned($random(seed)) % 64);
    cmd(4, cv);
    read_chk();
    cmd(14, 16'h0000);
    cmd(7, 16'h0000);
    cmd(4, cv);
    read_chk();
    check({10'h000, CURRENT_GAIN}, {10'h000, cv[5:0]}, "gain");
    during(11, 1'b0);
    load(32);
    grayscale_clock_run(60);
    cmd(3, 16'h0000);
    grayscale_clock_run(1100);
    fork
      grayscale_clock_run(130);
      load(32);
    join
    grayscale_clock_run(60);
    cmd(3, 16'h0000);
    grayscale_clock_run(300);
    during(11, 1'b1);
    during(1, 1'b0);
    during(12, 1'b0);
    during(12, 1'b1);
    during(1, 1'b0);
    cmd(10, 16'h0000);
    grayscale_clock_run(30);
    check({10'h000, CURRENT_GAIN}, {10'h000, cv[5:0]}, "kept");
    read_chk();
    cmd(14, 16'h0000);
    cmd(4, 16'h1000 | {10'h000, cv[5:0]});
    load(16);
    grayscale_clock_run(60);
    cmd(3, 16'h0000);
    grayscale_clock_run(1100);
    print_verdict();
  end

  initial
  begin
    #1000000;
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule

// ---- slp_pkg.sv ----
package slp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int WORD_W = 16;
  localparam int MAX_LINES = 8;
  localparam int LINE_W = 3;
  localparam int SLOT_W = 4;
  localparam int PTR_W = LINE_W + SLOT_W;
  localparam int MEM_AW = PTR_W + 1;
  localparam int MEM_WORDS = 2 * MAX_LINES * NUM_CH;
  localparam int GAIN_W = 6;

  // ----------------------------------------------------------------
  // configuration register layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'h032B;
  localparam int CFG_GS_SRC_BIT = 13;
  localparam int CFG_MODE14_BIT = 12;
  localparam int CFG_LINES_LSB = 8;
  localparam int CFG_GAIN_LSB = 0;

  // ----------------------------------------------------------------
  // commands: shift clock rising edges seen while the strobe is high
  // ----------------------------------------------------------------
  localparam int CMD_W = 5;
  localparam logic [CMD_W-1:0] CMD_WORD_LATCH = 5'h01;
  localparam logic [CMD_W-1:0] CMD_FRAME_SYNC = 5'h03;
  localparam logic [CMD_W-1:0] CMD_WRITE_CFG = 5'h04;
  localparam logic [CMD_W-1:0] CMD_READ_CFG = 5'h05;
  localparam logic [CMD_W-1:0] CMD_SOFT_RESET = 5'h0A;
  localparam logic [CMD_W-1:0] CMD_FORCE_ON = 5'h0B;
  localparam logic [CMD_W-1:0] CMD_FORCE_OFF = 5'h0C;
  localparam logic [CMD_W-1:0] CMD_UNLOCK = 5'h0E;
  localparam logic [CMD_W-1:0] CMD_MAX = 5'h1F;

  // ----------------------------------------------------------------
  // pwm timing, in grayscale clocks
  // ----------------------------------------------------------------
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] GS_LAST = 11'h3FF;
  localparam logic [CNT_W-1:0] GS_OFF = 11'h400;
  localparam int SECT_W = 6;
  localparam logic [SECT_W-1:0] SECT_LAST_16 = 6'h3F;
  localparam logic [SECT_W-1:0] SECT_LAST_14 = 6'h0F;
  localparam logic [4:0] RD_BITS = 5'h10;

  // ----------------------------------------------------------------
  // display state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLP_IDLE = 2'b01,
    SLP_ACTIVE = 2'b10
  } slp_disp_e;

endpackage

// ---- slp_sync.sv ----
`timescale 1ns/1ns
module slp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // two-stage synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      dout <= '0;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule
